// file: hdl/dsa_channel_ctrl.sv
`timescale 1ns/1ns
module dsa_channel_ctrl #(
	parameter int unsigned NCH = dsa_pkg::NCH_DEF,
	parameter int unsigned PW  = dsa_pkg::PW_DEF,
	parameter int unsigned AW  = dsa_pkg::AW_DEF,
	parameter int unsigned DW  = dsa_pkg::DW_DEF
) (
	input  wire logic                               clk_sys,
	input  wire logic                               rst_n,
	input  wire logic                               engine_on,          // whole engine on
	input  wire logic                               engine_suspend,     // global suspend
	input  wire logic [NCH-1:0]                     channel_enable_bit, // per channel enable
	input  wire logic [NCH-1:0]                     ch_abort,           // abort pulse
	input  wire logic [NCH-1:0]                     ch_force,           // software trigger
	input  wire logic [NCH-1:0]                     trig,               // peripheral flags
	input  wire logic [NCH-1:0]                     pm_enable,          // pattern match mode
	input  wire logic [NCH-1:0][dsa_pkg::PAT_W-1:0] pm_pattern,         // match value
	input  wire logic [NCH-1:0][AW-1:0]             src_base,           // source start address
	input  wire logic [NCH-1:0][AW-1:0]             dst_base,           // destination start
	input  wire logic [NCH-1:0][PW-1:0]             blk_size,           // words per block
	input  wire logic [NCH-1:0][PW-1:0]             cell_size,          // words per trigger
	input  wire logic                               bus_ack,            // beat accepted
	input  wire logic [DW-1:0]                      bus_rdata,          // read data
	output logic                                    bus_req,            // beat requested
	output logic                                    bus_we,             // beat is a write
	output logic [AW-1:0]                           bus_addr,           // beat address
	output logic [DW-1:0]                           bus_wdata,          // write data
	output logic                                    engine_busy,        // sequencer out of idle, registered
	output logic [NCH-1:0]                          ch_event,           // pending events
	output logic [NCH-1:0]                          blk_done,           // block done pulse
	output logic [dsa_pkg::CRC_W-1:0]               crc_result,         // running crc
	output logic [NCH-1:0][PW-1:0]                  src_ptr,            // source pointers
	output logic [NCH-1:0][PW-1:0]                  dst_ptr,            // destination pointers
	output logic [NCH-1:0][PW-1:0]                  cell_ptr            // cell pointers
);

	localparam int unsigned CW = (NCH > 1) ? $clog2(NCH) : 1;

	// lowest numbered eligible channel wins
	function automatic logic [CW-1:0] dsa_pick(input logic [NCH-1:0] req);
		logic [CW-1:0] idx;
		idx = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = CW'(i);
			end
		end
		return idx;
	endfunction : dsa_pick

	// crc over one whole word, msb first
	function automatic logic [15:0] dsa_crc_word(input logic [15:0] c, input logic [DW-1:0] d);
		logic [15:0] r;
		r = c;
		for (int b = DW - 1; b >= 0; b--) begin
			if (r[15] ^ d[b]) begin
				r = (r << 1) ^ dsa_pkg::CRC_POLY;
			end else begin
				r = r << 1;
			end
		end
		return r;
	endfunction : dsa_crc_word

	// word pointer to byte address offset
	function automatic logic [AW-1:0] dsa_addr(input logic [AW-1:0] base, input logic [PW-1:0] p);
		return base + (AW'(p) << dsa_pkg::WORD_SHIFT);
	endfunction : dsa_addr

	dsa_pkg::dsa_state_t          state_q;       // sequencer
	logic [CW-1:0]                act_q;         // channel on the bus
	logic [DW-1:0]                data_q;        // word in transit
	logic [15:0]                  crc_q;         // crc accumulator
	logic [NCH-1:0]               event_q;       // pending trigger events
	logic [NCH-1:0]               event_d;
	logic [NCH-1:0]               trig_q;        // previous trigger level
	logic [NCH-1:0]               abort_pend_q;  // abort waiting for its channel's transfer to end
	logic [NCH-1:0]               done_q;        // block done pulse
	logic                         req_q;
	logic                         we_q;
	logic [AW-1:0]                addr_q;
	logic [DW-1:0]                wdata_q;
	logic [NCH-1:0][PW-1:0]       sp_q;
	logic [NCH-1:0][PW-1:0]       dp_q;
	logic [NCH-1:0][PW-1:0]       cp_q;

	// eligibility and start decode
	wire            run_ok   = engine_on & ~engine_suspend;
	wire [NCH-1:0]  eligible = event_q & channel_enable_bit & ~abort_pend_q & {NCH{run_ok}};
	wire            idle     = (state_q == dsa_pkg::DSA_IDLE);
	wire            start    = idle & (|eligible);
	wire [CW-1:0]   pick     = dsa_pick(eligible);

	// end-of-beat decode for the active channel
	wire [PW-1:0]   sp_nxt   = PW'(sp_q[act_q] + 1'b1);
	wire [PW-1:0]   dp_nxt   = PW'(dp_q[act_q] + 1'b1);
	wire [PW-1:0]   cp_nxt   = PW'(cp_q[act_q] + 1'b1);
	wire            matched  = pm_enable[act_q] & (data_q[dsa_pkg::PAT_W-1:0] == pm_pattern[act_q]);
	wire            blk_end  = (sp_nxt == blk_size[act_q]) | matched;
	wire            cell_end = (cp_nxt == cell_size[act_q]) | blk_end;
	wire            wr_done  = (state_q == dsa_pkg::DSA_WRITE) & bus_ack;
	wire            ap_done  = (state_q == dsa_pkg::DSA_APPEND) & bus_ack;
	wire            keep_on  = channel_enable_bit[act_q] & run_ok;
	wire            start_blk = (sp_q[pick] == dsa_pkg::PTR_RST[PW-1:0])
	                          & (cp_q[pick] == dsa_pkg::PTR_RST[PW-1:0]);

	// per-channel decode of event set, event clear and abort application
	logic [NCH-1:0] ev_set;
	logic [NCH-1:0] ev_clr;
	logic [NCH-1:0] ab_go;
	logic [NCH-1:0] ab_keep;
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ev_set[i]  = (trig[i] & ~trig_q[i] & ~engine_suspend) | ch_force[i];
			// abort waits until its channel is no longer the active channel, i.e. its transfer has ended at cell end or stopped early because keep_on dropped
			ab_go[i]   = abort_pend_q[i] & (idle | (act_q != CW'(i)));
			ab_keep[i] = ~channel_enable_bit[i] & (cp_q[i] != dsa_pkg::PTR_RST[PW-1:0]);
			// completion clears event only if still enabled
			ev_clr[i]  = ab_go[i]
			           | ((wr_done & cell_end & ~(blk_end & pm_enable[i]))
			              | ap_done) & (act_q == CW'(i)) & channel_enable_bit[i];
			// a new event wins over a clear in the same cycle
			event_d[i] = (event_q[i] & ~ev_clr[i]) | ev_set[i];
		end
	end

	// event flags, trigger history and pending aborts
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			event_q      <= '0;
			trig_q       <= '0;
			abort_pend_q <= '0;
		end else begin
			event_q      <= event_d;
			trig_q       <= trig;
			abort_pend_q <= (abort_pend_q & ~ab_go) | ch_abort;
		end
	end

	// sequencer and bus master
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= dsa_pkg::DSA_IDLE;
			act_q   <= '0;
			req_q   <= 1'b0;
			we_q    <= 1'b0;
			addr_q  <= '0;
			wdata_q <= dsa_pkg::WORD_RST[DW-1:0];
			data_q  <= dsa_pkg::WORD_RST[DW-1:0];
			crc_q   <= dsa_pkg::CRC_INIT;
			done_q  <= '0;
		end else begin
			done_q <= '0;
			case (state_q)
				// take a channel and issue its first read
				dsa_pkg::DSA_IDLE: begin
					if (start) begin
						act_q   <= pick;
						req_q   <= 1'b1;
						we_q    <= 1'b0;
						addr_q  <= dsa_addr(src_base[pick], sp_q[pick]);
						state_q <= dsa_pkg::DSA_READ;
						if (start_blk) begin
							crc_q <= dsa_pkg::CRC_INIT;
						end
					end
				end
				dsa_pkg::DSA_READ: begin
					if (bus_ack) begin
						data_q  <= bus_rdata;
						crc_q   <= dsa_crc_word(crc_q, bus_rdata);
						we_q    <= 1'b1;
						wdata_q <= bus_rdata;
						addr_q  <= dsa_addr(dst_base[act_q], dp_q[act_q]);
						state_q <= dsa_pkg::DSA_WRITE;
					end
				end
				// write beat held; next read only while still running
				dsa_pkg::DSA_WRITE: begin
					if (bus_ack) begin
						if (blk_end & pm_enable[act_q]) begin
							// append crc after the matched or last word of the block
							wdata_q <= DW'(crc_q);
							addr_q  <= dsa_addr(dst_base[act_q], dp_nxt);
							state_q <= dsa_pkg::DSA_APPEND;
						end else if (cell_end | ~keep_on) begin
							req_q   <= 1'b0;
							we_q    <= 1'b0;
							state_q <= dsa_pkg::DSA_IDLE;
							done_q[act_q] <= blk_end;
						end else begin
							we_q    <= 1'b0;
							addr_q  <= dsa_addr(src_base[act_q], sp_nxt);
							state_q <= dsa_pkg::DSA_READ;
						end
					end
				end
				// crc word written, block closes
				dsa_pkg::DSA_APPEND: begin
					if (bus_ack) begin
						req_q   <= 1'b0;
						we_q    <= 1'b0;
						state_q <= dsa_pkg::DSA_IDLE;
						done_q[act_q] <= 1'b1;
					end
				end
				default: begin
					req_q   <= 1'b0;
					we_q    <= 1'b0;
					state_q <= dsa_pkg::DSA_IDLE;
				end
			endcase
		end
	end

	// source, destination and cell pointers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= '0;
			dp_q <= '0;
			cp_q <= '0;
		end else begin
			// advance or wrap after each written data word, not after the appended crc word
			if (wr_done) begin
				if (blk_end) begin
					sp_q[act_q] <= dsa_pkg::PTR_RST[PW-1:0];
					dp_q[act_q] <= dsa_pkg::PTR_RST[PW-1:0];
					cp_q[act_q] <= dsa_pkg::PTR_RST[PW-1:0];
				end else begin
					sp_q[act_q] <= sp_nxt;
					dp_q[act_q] <= dp_nxt;
					cp_q[act_q] <= cell_end ? dsa_pkg::PTR_RST[PW-1:0] : cp_nxt;
				end
			end
			// abort resets pointers unless channel disabled mid-cell
			for (int i = 0; i < NCH; i++) begin
				if (ab_go[i] & ~ab_keep[i]) begin
					sp_q[i] <= dsa_pkg::PTR_RST[PW-1:0];
					dp_q[i] <= dsa_pkg::PTR_RST[PW-1:0];
					cp_q[i] <= dsa_pkg::PTR_RST[PW-1:0];
				end
			end
		end
	end

	// busy from start until one cycle after the sequencer is back in idle
	logic busy_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= ~idle | start;
		end
	end

	// outputs straight from flip-flops
	assign bus_req     = req_q;
	assign bus_we      = we_q;
	assign bus_addr    = addr_q;
	assign bus_wdata   = wdata_q;
	assign engine_busy = busy_q;
	assign ch_event    = event_q;
	assign blk_done    = done_q;
	assign crc_result  = crc_q;
	assign src_ptr     = sp_q;
	assign dst_ptr     = dp_q;
	assign cell_ptr    = cp_q;

endmodule : dsa_channel_ctrl

// file: hdl/dsa_pkg.sv
package dsa_pkg;

	// default geometry of the engine
	localparam int unsigned NCH_DEF    = 4;              // channels
	localparam int unsigned PW_DEF     = 16;             // pointer and size width in words
	localparam int unsigned AW_DEF     = 32;             // system bus address width
	localparam int unsigned DW_DEF     = 32;             // system bus data width

	// byte address of a word pointer is the pointer shifted by this many bits
	localparam int unsigned WORD_SHIFT = 2;

	// pattern match compares this many low bits of each read word
	localparam int unsigned PAT_W      = 8;

	// crc unit
	localparam int unsigned CRC_W      = 16;
	localparam logic [15:0] CRC_POLY   = 16'h1021;       // feedback polynomial
	localparam logic [15:0] CRC_INIT   = 16'hffff;       // seed at block start

	// reset values
	localparam logic [15:0] PTR_RST    = 16'h0000;       // pointers after reset or abort
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;  // bus words after reset

	// engine sequencer, gray coded along idle-read-write-append
	typedef enum logic [1:0] {
		DSA_IDLE   = 2'b00,
		DSA_READ   = 2'b01,
		DSA_WRITE  = 2'b11,
		DSA_APPEND = 2'b10
	} dsa_state_t;

endpackage : dsa_pkg

// file: test/dsa_channel_ctrl_assertions.sv
`timescale 1ns/1ns
module dsa_channel_ctrl_assertions #(
	parameter int unsigned NCH = 4,
	parameter int unsigned AW  = 32
) (
	input wire logic           clk_sys,
	input wire logic           rst_n,
	input wire logic           engine_on,
	input wire logic           engine_suspend,
	input wire logic [NCH-1:0] channel_enable_bit,
	input wire logic [NCH-1:0] ch_abort,
	input wire logic [NCH-1:0] ch_force,
	input wire logic [NCH-1:0] trig,
	input wire logic           bus_ack,
	input wire logic           bus_req,
	input wire logic           bus_we,
	input wire logic [AW-1:0]  bus_addr,
	input wire logic           engine_busy,
	input wire logic [NCH-1:0] ch_event,
	input wire logic [NCH-1:0] blk_done
);
	// one clock domain, reset gates every check
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_beat_held: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we))
		else $error("open beat changed before ack");
	a_write_follows: assert property (bus_req && bus_ack && !bus_we |=> bus_req && bus_we)
		else $error("read not followed by its write");
	a_off_no_start: assert property (!engine_on && !engine_busy && !bus_req |=> !bus_req)
		else $error("beat started while engine off");
	a_trig_taken: assert property ($rose(trig[0]) && !engine_suspend |=> ch_event[0])
		else $error("trigger edge not captured");
	a_suspend_drops: assert property (engine_suspend && !ch_force[0] && !ch_event[0] |=> !ch_event[0])
		else $error("event captured during suspend");
	a_force_taken: assert property (ch_force[0] |=> ch_event[0] [*2])
		else $error("force did not raise event");
	a_event_kept: assert property (bus_req && bus_ack && bus_we && !channel_enable_bit[1] && ch_event[1] && !ch_abort[1] |=> ch_event[1])
		else $error("event cleared while channel disabled");
	a_start_on_event: assert property ($rose(bus_req) |-> $past(ch_event) != '0)
		else $error("beat started with no pending event");
	a_done_after_ack: assert property ($rose(|blk_done) |-> $past(bus_ack) && $past(bus_we))
		else $error("block done without write ack");

	// main scenarios reached
	c_start: cover property ($rose(bus_req));
	c_disabled_ack: cover property (bus_ack && !channel_enable_bit[1]);
	c_done: cover property ($rose(|blk_done));
endmodule : dsa_channel_ctrl_assertions

// file: test/dsa_mem_model.sv
`timescale 1ns/1ns
module dsa_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        bus_req,
	input  wire logic [31:0] bus_addr,
	input  wire logic [3:0]  dly,
	output logic             bus_ack,
	output logic [31:0]      bus_rdata
);
	logic [3:0] cnt_q; // wait cycles of the open beat
	// one-cycle ack after dly+1 wait cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
			cnt_q   <= 4'h0;
		end else begin
			bus_ack <= bus_req && !bus_ack && cnt_q >= dly;
			cnt_q   <= (bus_req && !bus_ack) ? cnt_q + 4'h1 : 4'h0;
		end
	end
	// data valid only with ack, inverted halves otherwise
	assign bus_rdata = bus_ack ? {bus_addr[15:0], ~bus_addr[15:0]} : {~bus_addr[15:0], bus_addr[15:0]};
endmodule : dsa_mem_model

// file: test/dsa_channel_ctrl_tb.sv
`timescale 1ns/1ns
module dsa_channel_ctrl_tb;
	logic             clk_sys, rst_n, engine_on, engine_suspend, bus_ack, bus_req, bus_we, engine_busy;
	logic [3:0]       channel_enable_bit, ch_abort, ch_force, trig, pm_enable, ch_event, blk_done, dly;
	logic [3:0][7:0]  pm_pattern;
	logic [3:0][31:0] src_base, dst_base;
	logic [3:0][15:0] blk_size, cell_size, src_ptr, dst_ptr, cell_ptr;
	logic [31:0]      bus_rdata, bus_addr, bus_wdata, wa, wd;
	logic [15:0]      crc_result;
	int               n_wr, n_fail, n_tests, cyc, n0, n_done;

	dsa_channel_ctrl i_dut (.*);
	dsa_mem_model i_mem (.*);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// write log and run limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (bus_req && bus_ack && bus_we) begin
			wa   <= bus_addr;
			wd   <= bus_wdata;
			n_wr <= n_wr + 1;
		end
		if (|blk_done) n_done <= n_done + 1;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// reference crc over one word, msb first, from the package constants
	function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [31:0] d);
		for (int b = 31; b >= 0; b--) begin
			c = (c[15] ^ d[b]) ? ((c << 1) ^ dsa_pkg::CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc_ref
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task force_ch(input int c);
		ch_force[c] <= 1'b1;
		tick(1);
		ch_force[c] <= 1'b0;
	endtask : force_ch
	task wait_wr(input int n);
		for (int k = 0; k < 300 && n_wr < n; k++) tick(1);
	endtask : wait_wr
	task wait_idle;
		for (int k = 0; k < 300 && (bus_req || engine_busy || k < 4); k++) tick(1);
	endtask : wait_idle
	task conclude;
		$display("counts: %0d checks, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	initial begin
		{rst_n, engine_on, engine_suspend, channel_enable_bit, ch_abort, ch_force, trig} = '0;
		{pm_enable, dly} = '0;
		for (int c = 0; c < 4; c++) begin
			src_base[c] = 32'h1000 * (c + 1);
			dst_base[c] = 32'h8000 + 32'h1000 * c;
			blk_size[c] = 16'h0002;
			cell_size[c] = 16'h0001;
			pm_pattern[c] = 8'hfb;
		end
		{blk_size[2], cell_size[2], blk_size[3], cell_size[3]} = {16'h8, 16'h4, 16'h4, 16'h4};
		pm_enable = 4'h8;
		tick(10);
		rst_n <= 1'b1;
		engine_on <= 1'b1;
		channel_enable_bit <= 4'hf;
		tick(2);
		trig[0] <= 1'b1;
		wait_wr(1);
		chk(wa, 32'h0000_8000);
		chk(wd, 32'h1000_efff);
		wait_idle();
		chk(src_ptr[0], 32'h1);
		$display("trigger test done");
		trig[0] <= 1'b0;
		engine_suspend <= 1'b1;
		tick(2);
		trig[0] <= 1'b1;
		tick(4);
		chk(ch_event[0], 1'b0);
		engine_suspend <= 1'b0;
		tick(6);
		chk(n_wr, 32'h1);
		force_ch(0);
		wait_wr(2);
		wait_idle();
		chk(wd, 32'h1004_effb);
		chk(src_ptr[0], 32'h0);
		$display("suspend test done");
		dly <= 4'h6;
		force_ch(1);
		tick(3);
		channel_enable_bit[1] <= 1'b0;
		engine_on <= 1'b0;
		wait_wr(3);
		wait_idle();
		chk(n_wr, 32'h3);
		chk(wd, 32'h2000_dfff);
		chk(ch_event[1], 1'b1);
		channel_enable_bit[1] <= 1'b1;
		engine_on <= 1'b1;
		wait_wr(4);
		chk(wa, 32'h0000_9004);
		$display("enable clear test done");
		force_ch(2);
		wait_wr(5);
		channel_enable_bit[2] <= 1'b0;
		wait_idle();
		chk(src_ptr[2], n_wr - 4);
		ch_abort[2] <= 1'b1;
		tick(1);
		ch_abort[2] <= 1'b0;
		tick(3);
		chk(src_ptr[2], n_wr - 4);
		chk(ch_event[2], 1'b0);
		channel_enable_bit[2] <= 1'b1;
		tick(1);
		ch_abort[2] <= 1'b1;
		tick(1);
		ch_abort[2] <= 1'b0;
		tick(3);
		chk(src_ptr[2], 32'h0);
		chk(cell_ptr[2], 32'h0);
		chk(dst_ptr[2], 32'h0);
		$display("abort test done");
		dly <= 4'h0;
		n0 = n_wr;
		force_ch(3);
		wait_wr(n0 + 3);
		wait_idle();
		chk(n_wr, n0 + 3);
		chk(wd, {16'h0000, crc_ref(crc_ref(dsa_pkg::CRC_INIT, 32'h4000_bfff), 32'h4004_bffb)});
		chk(crc_result, crc_ref(crc_ref(dsa_pkg::CRC_INIT, 32'h4000_bfff), 32'h4004_bffb));
		chk(wa, 32'h0000_b008);
		chk(n_done, 32'h3);
		engine_on <= 1'b0;
		tick(4);
		chk(bus_req, 1'b0);
		$display("pattern test done");
		conclude();
	end
endmodule : dsa_channel_ctrl_tb

bind dsa_channel_ctrl dsa_channel_ctrl_assertions #(.NCH(NCH), .AW(AW)) i_chk (.clk_sys, .rst_n,
	.engine_on, .engine_suspend, .channel_enable_bit, .ch_abort, .ch_force, .trig, .bus_ack,
	.bus_req, .bus_we, .bus_addr, .engine_busy, .ch_event, .blk_done);
